// ===== verilog/scr_pkg.sv
// Constants shared by the sideband command originator: opcodes, codes and timing.
// Assumes a single 25 MHz core clock and an external frame engine on the link.
//
// Summary of operation
// - Reissue with retry bit after timeout/bad check.
// - Abort check on a malformed command, or code 0x90, means unsupported.
// - Opcodes 0x01, 0xa1, 0xa5; domain 1 +1.
// - Opcodes 0xb1, 0x61, 0xe1; domain 1 +1.
// - Local config write 0xe5, domain 1 0xe6.
// - Completion bit 7 set means fail, clear pass.
// - Originator tolerates every code, applies bit 7.
// - Bad/abort check: retry, three attempts then error.
// - Class 0x8x: retry, three attempts then notify.
// - Class 0x9x: no retry, abandon and notify.
// - All zeros: idle low 1ms, retry, three max.
package scr_pkg;

  // ****************************************************************
  // Command opcodes for domain 0 and domain 1.
  // ****************************************************************
  localparam logic [7:0] OPC_TEMP_RD_D0 = 8'h01; // Temperature read.
  localparam logic [7:0] OPC_TEMP_RD_D1 = 8'h02;
  localparam logic [7:0] OPC_PKG_RD_D0 = 8'hA1; // Package setting read.
  localparam logic [7:0] OPC_PKG_RD_D1 = 8'hA2;
  localparam logic [7:0] OPC_PKG_WR_D0 = 8'hA5; // Package setting write.
  localparam logic [7:0] OPC_PKG_WR_D1 = 8'hA6;
  localparam logic [7:0] OPC_MSR_RD_D0 = 8'hB1; // Core model register read.
  localparam logic [7:0] OPC_MSR_RD_D1 = 8'hB2;
  localparam logic [7:0] OPC_RCFG_RD_D0 = 8'h61; // Remote config read.
  localparam logic [7:0] OPC_RCFG_RD_D1 = 8'h62;
  localparam logic [7:0] OPC_LCFG_RD_D0 = 8'hE1; // Local config read.
  localparam logic [7:0] OPC_LCFG_RD_D1 = 8'hE2;
  localparam logic [7:0] OPC_LCFG_WR_D0 = 8'hE5; // Local config write.
  localparam logic [7:0] OPC_LCFG_WR_D1 = 8'hE6;

  // ****************************************************************
  // Domain field encodings.
  // ****************************************************************
  localparam logic [1:0] DOM_NONE = 2'h0; // Opcode carries no domain.
  localparam logic [1:0] DOM_0 = 2'h1; // Domain 0.
  localparam logic [1:0] DOM_1 = 2'h2; // Domain 1.

  // ****************************************************************
  // Completion codes and the frame check status from the frame engine.
  // ****************************************************************
  localparam logic [7:0] CC_PASSED = 8'h40; // Command passed.
  localparam logic [7:0] CC_UNKNOWN = 8'h90; // Unknown or illegal request.
  localparam logic [3:0] CC_CLASS_RETRY = 4'h8; // Timeout class.
  localparam logic [3:0] CC_CLASS_FATAL = 4'h9; // Abandon class.
  localparam logic [1:0] FCS_GOOD = 2'h0; // Frame check was good.
  localparam logic [1:0] FCS_BAD = 2'h1; // Frame check was bad.
  localparam logic [1:0] FCS_ABORT = 2'h2; // Frame check was an abort value.

  // ****************************************************************
  // Final result codes reported to the application.
  // ****************************************************************
  localparam logic [2:0] RES_PASS = 3'h0; // Command passed.
  localparam logic [2:0] RES_DEV_ERR = 3'h1; // Client device error.
  localparam logic [2:0] RES_NO_RESP = 3'h2; // Client could not generate a response.
  localparam logic [2:0] RES_ABANDON = 3'h3; // Failing code, abandoned.
  localparam logic [2:0] RES_UNRESP = 3'h4; // Client unresponsive.
  localparam logic [2:0] RES_UNSUPP = 3'h5; // Command unsupported.

  // ****************************************************************
  // Attempt limit and bus idle timing.
  // ****************************************************************
  localparam logic [1:0] MAX_ATTEMPTS = 2'h3; // Attempts before giving up.
  localparam int IDLE_TIME_NS = 1000000; // Forced idle time, 1 ms.
  localparam int CLK_PERIOD_NS = 40; // Core clock period.
  localparam int IDLE_CYCLES = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ISSUE = 5'h02,
    ST_WAIT = 5'h04,
    ST_QUIET = 5'h08,
    ST_REPORT = 5'h10
  } scr_state_e;

endpackage

// ===== verilog/scr_originator.sv
// Command originator that sends requests to the client and applies the retry policy.
// Assumes an external frame engine that sends one frame per start pulse and
// returns one done pulse with the frame check status and completion code.
`timescale 1ns/1ps

module scr_originator #(
  parameter int IDLE_CYCLES = scr_pkg::IDLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic app_req_valid,
  input wire logic [7:0] app_opcode,
  input wire logic app_wellformed,
  output logic app_ready,
  output logic app_done,
  output logic [2:0] app_result,
  output logic [7:0] app_cc,
  output logic lnk_start,
  output logic [7:0] lnk_opcode,
  output logic [1:0] lnk_domain,
  output logic lnk_retry,
  output logic lnk_idle_low,
  input wire logic lnk_done,
  input wire logic [1:0] lnk_fcs,
  input wire logic lnk_has_cc,
  input wire logic [7:0] lnk_cc,
  input wire logic lnk_all_zero
);
  import scr_pkg::*;

  localparam int CW = $clog2(IDLE_CYCLES + 1);

  // Refuse an idle time shorter than one cycle.
  if (IDLE_CYCLES < 1)
  begin : g_bad_idle
    $error("IDLE_CYCLES must be at least one");
  end

  // ****************************************************************
  // Decoding of the domain field from an opcode.
  // ****************************************************************

  // Returns the domain encoding that belongs to a known opcode.
  function automatic logic [1:0] opcode_domain(input logic [7:0] opc);
    logic [1:0] dom;
    dom = DOM_NONE;
    unique case (opc)
      OPC_TEMP_RD_D0, OPC_PKG_RD_D0, OPC_PKG_WR_D0: dom = DOM_0;
      OPC_TEMP_RD_D1, OPC_PKG_RD_D1, OPC_PKG_WR_D1: dom = DOM_1;
      OPC_MSR_RD_D0, OPC_RCFG_RD_D0, OPC_LCFG_RD_D0: dom = DOM_0;
      OPC_MSR_RD_D1, OPC_RCFG_RD_D1, OPC_LCFG_RD_D1: dom = DOM_1;
      OPC_LCFG_WR_D0: dom = DOM_0;
      OPC_LCFG_WR_D1: dom = DOM_1;
      default: dom = DOM_NONE;
    endcase
    return dom;
  endfunction

  // ****************************************************************
  // State of the controller.
  // ****************************************************************
  scr_state_e state_reg; // Current state.
  scr_state_e state_next;
  logic [1:0] attempts_reg; // Frames sent for this command.
  logic [1:0] attempts_next;
  logic wf_reg; // Command was legal and well formed.
  logic wf_next;
  logic [CW-1:0] quiet_reg; // Remaining forced idle cycles.
  logic [CW-1:0] quiet_next;
  logic ready_next;
  logic done_next;
  logic [2:0] result_next;
  logic [7:0] cc_next;
  logic start_next;
  logic [7:0] opcode_next;
  logic [1:0] domain_next;
  logic retry_next;
  logic idle_low_next;

  // Computes the next state and outputs from the response policy.
  always_comb
  begin
    logic last_try;
    logic do_retry;
    logic [2:0] fail_res;
    last_try = (attempts_reg == MAX_ATTEMPTS);
    do_retry = 1'b0;
    fail_res = RES_PASS;
    state_next = state_reg;
    attempts_next = attempts_reg;
    wf_next = wf_reg;
    quiet_next = quiet_reg;
    ready_next = app_ready;
    done_next = 1'b0;
    result_next = app_result;
    cc_next = app_cc;
    start_next = 1'b0;
    opcode_next = lnk_opcode;
    domain_next = lnk_domain;
    retry_next = lnk_retry;
    idle_low_next = lnk_idle_low;
    unique case (state_reg)
      // Waits for a new command from the application.
      ST_IDLE:
      begin
        ready_next = 1'b1;
        if (app_req_valid)
        begin
          ready_next = 1'b0;
          opcode_next = app_opcode;
          domain_next = opcode_domain(app_opcode);
          wf_next = app_wellformed;
          attempts_next = 2'h0;
          retry_next = 1'b0;
          state_next = ST_ISSUE;
        end
      end
      // Sends one frame; every frame after the first carries the retry bit.
      ST_ISSUE:
      begin
        start_next = 1'b1;
        attempts_next = attempts_reg + 2'h1;
        state_next = ST_WAIT;
      end
      // Classifies the response once the frame engine finishes.
      ST_WAIT:
      begin
        if (lnk_done)
        begin
          cc_next = lnk_has_cc ? lnk_cc : 8'h00;
          if (lnk_all_zero)
          begin
            do_retry = !last_try;
            fail_res = RES_UNRESP;
          end
          else if (lnk_fcs == FCS_BAD)
          begin
            do_retry = !last_try;
            fail_res = RES_DEV_ERR;
          end
          else if (lnk_fcs != FCS_GOOD)
          begin
            // An abort after a malformed command points at the command.
            do_retry = !last_try;
            fail_res = wf_reg ? RES_DEV_ERR : RES_UNSUPP;
          end
          else if (!lnk_has_cc || !lnk_cc[7])
          begin
            fail_res = RES_PASS;
          end
          else if (lnk_cc[7:4] == CC_CLASS_RETRY)
          begin
            do_retry = !last_try;
            fail_res = RES_NO_RESP;
          end
          else if (lnk_cc == CC_UNKNOWN)
          begin
            fail_res = RES_UNSUPP;
          end
          else
          begin
            // Class 0x9x and any other failing code end at once.
            fail_res = RES_ABANDON;
          end
          if (do_retry)
          begin
            retry_next = 1'b1;
            if (lnk_all_zero)
            begin
              idle_low_next = 1'b1;
              quiet_next = CW'(IDLE_CYCLES - 1);
              state_next = ST_QUIET;
            end
            else
            begin
              state_next = ST_ISSUE;
            end
          end
          else
          begin
            result_next = fail_res;
            state_next = ST_REPORT;
          end
        end
      end
      // Holds the bus low for the forced idle time, then resends.
      ST_QUIET:
      begin
        if (quiet_reg == '0)
        begin
          idle_low_next = 1'b0;
          state_next = ST_ISSUE;
        end
        else
        begin
          quiet_next = quiet_reg - CW'(1);
        end
      end
      // Reports the final result for one cycle.
      ST_REPORT:
      begin
        done_next = 1'b1;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers the state and every output.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      attempts_reg <= 2'h0;
      wf_reg <= 1'b0;
      quiet_reg <= '0;
      app_ready <= 1'b0;
      app_done <= 1'b0;
      app_result <= RES_PASS;
      app_cc <= 8'h00;
      lnk_start <= 1'b0;
      lnk_opcode <= 8'h00;
      lnk_domain <= DOM_NONE;
      lnk_retry <= 1'b0;
      lnk_idle_low <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      attempts_reg <= attempts_next;
      wf_reg <= wf_next;
      quiet_reg <= quiet_next;
      app_ready <= ready_next;
      app_done <= done_next;
      app_result <= result_next;
      app_cc <= cc_next;
      lnk_start <= start_next;
      lnk_opcode <= opcode_next;
      lnk_domain <= domain_next;
      lnk_retry <= retry_next;
      lnk_idle_low <= idle_low_next;
    end
  end

  // ****************************************************************
  // Checks on the response policy.
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // Marks that the current attempt is the last one allowed.
  logic last_ok;
  assign last_ok = (attempts_reg == MAX_ATTEMPTS);

  // A response arrives while a frame is outstanding.
  sequence resp_s;
    state_reg == ST_WAIT && lnk_done;
  endsequence
  // A good frame check carrying a failing code of a given class.
  sequence class_s(logic [3:0] cls);
    resp_s and (!lnk_all_zero && lnk_fcs == FCS_GOOD && lnk_has_cc && lnk_cc[7:4] == cls);
  endsequence

  retry_bit_a: assert property (lnk_start |-> lnk_retry == (attempts_reg > 2'h1))
    else $error("retry bit does not match attempt number");
  attempt_cap_a: assert property (resp_s ##0 last_ok |=> !lnk_start ##1 app_done)
    else $error("attempt beyond the third one started");
  pass_mask_a: assert property (app_done && app_result == RES_PASS |-> !app_cc[7])
    else $error("failing code reported as pass");
  unsupp_cc_a: assert property (app_done && app_cc == CC_UNKNOWN |-> app_result == RES_UNSUPP)
    else $error("code 0x90 not reported as unsupported");
  class8_retry_a: assert property (class_s(CC_CLASS_RETRY) ##0 !last_ok |-> ##2 lnk_start)
    else $error("timeout class not retried");
  class8_stop_a: assert property (class_s(CC_CLASS_RETRY) ##0 last_ok |=> !lnk_start ##1 (app_done && app_result == RES_NO_RESP))
    else $error("timeout class not given up after three attempts");
  class9_stop_a: assert property (class_s(CC_CLASS_FATAL) |=> !lnk_start ##1 (app_done && !lnk_start))
    else $error("fatal class was retried");
  zero_quiet_a: assert property (resp_s ##0 (lnk_all_zero && !last_ok) |=> lnk_idle_low && !lnk_start)
    else $error("all-zero response not followed by forced idle");
  quiet_hold_a: assert property (lnk_idle_low |-> !lnk_start)
    else $error("frame started during forced idle");
  quiet_end_a: assert property ($fell(lnk_idle_low) |=> lnk_start)
    else $error("no resend after forced idle");

endmodule

// ===== sim/scr_client_model.sv
// Behavioural model of the managed client together with its frame engine.
// Assumes the bench sets the cfg inputs before it raises each command.
`timescale 1ns/1ps

module scr_client_model #(
  parameter logic [7:0] INFO_OPC = 8'hF7, // Info query opcode; the value is arbitrary.
  parameter logic [7:0] PROTO_REV = 8'h10 // Claimed protocol revision; the value is arbitrary.
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cfg_slow,
  input wire logic [2:0] cfg_fault,
  input wire logic [7:0] cfg_code,
  input wire logic [1:0] cfg_fail_n,
  input wire logic lnk_start,
  input wire logic [7:0] lnk_opcode,
  input wire logic [1:0] lnk_domain,
  input wire logic lnk_retry,
  output logic lnk_done,
  output logic [1:0] lnk_fcs,
  output logic lnk_has_cc,
  output logic [7:0] lnk_cc,
  output logic lnk_all_zero,
  output logic [1:0] frame_cnt,
  output logic [2:0] retry_log,
  output logic sem_err
);
  import scr_pkg::*;

  logic sem_held; // Resource held while a timed-out request waits for its retry.

  // Only the documented opcodes of both domains are understood.
  function automatic logic known(input logic [7:0] op);
    case (op)
      8'h01, 8'h02, 8'hA1, 8'hA2, 8'hA5, 8'hA6, 8'hB1, 8'hB2,
      8'h61, 8'h62, 8'hE1, 8'hE2, 8'hE5, 8'hE6: known = 1'b1;
      default: known = 1'b0;
    endcase
  endfunction

  initial
  begin
    {lnk_done, lnk_fcs, lnk_has_cc, lnk_cc, lnk_all_zero} = 13'h0;
    {frame_cnt, retry_log, sem_held, sem_err} = 7'h0;
  end

  // One response per start; outside the done cycle the lines show garbage.
  always
  begin
    @(posedge core_clk);
    if (!sys_rst && lnk_start)
    begin
      // A fresh request while the semaphore is held before the third try means no retry.
      if (!lnk_retry && sem_held && frame_cnt != 2'h3)
        sem_err = 1'b1;
      // A retried request is a retrieval of the pending result, never a restart.
      frame_cnt = lnk_retry ? frame_cnt + 2'h1 : 2'h1;
      retry_log = lnk_retry ? {retry_log[1:0], 1'b1} : 3'h0;
      repeat (cfg_slow ? 12 : 1) @(posedge core_clk);
      #1;
      lnk_done = 1'b1;
      lnk_fcs = FCS_GOOD;
      lnk_has_cc = 1'b1;
      lnk_cc = CC_PASSED;
      lnk_all_zero = 1'b0;
      if (lnk_opcode == INFO_OPC)
        lnk_cc = PROTO_REV; // The info query returns the implemented revision.
      else if (!known(lnk_opcode) || frame_cnt <= cfg_fail_n && cfg_fault inside {3'h1, 3'h2})
      begin
        // Unknown opcodes and a broken assured write both abort.
        lnk_fcs = (known(lnk_opcode) && cfg_fault == 3'h1) ? FCS_BAD : FCS_ABORT;
        lnk_has_cc = 1'b0;
        lnk_cc = 8'hC3;
      end
      else if (frame_cnt <= cfg_fail_n && cfg_fault == 3'h3)
        {lnk_has_cc, lnk_cc, lnk_all_zero} = 10'h001;
      else if (frame_cnt <= cfg_fail_n)
        lnk_cc = cfg_code;
      // The semaphore stays taken until a retry collects the answer.
      sem_held = (lnk_cc[7:4] == 4'h8);
      @(posedge core_clk);
      #1;
      lnk_done = 1'b0;
      {lnk_fcs, lnk_cc} = ~{lnk_fcs, lnk_cc};
    end
  end
endmodule

// ===== sim/sideband_cmd_response_policy_tb.sv
// Self-checking bench for the command originator and its retry policy.
// Assumes the client model in scr_client_model.sv; idle time shortened to 8.
`timescale 1ns/1ps

module sideband_cmd_response_policy_tb;
  import scr_pkg::*;

  localparam int IDLE_N = 8; // Short forced-idle span for simulation.
  localparam logic [7:0] INFO_OPC = 8'hF7; // Info query opcode; the value is arbitrary.
  localparam logic [7:0] PROTO_REV = 8'h10; // Claimed revision; the value is arbitrary.
  logic core_clk = 1'b0, sys_rst = 1'b1, app_req_valid = 1'b0, app_wellformed = 1'b1;
  logic [7:0] app_opcode = 8'h0, cfg_code = 8'h0, lnk_opcode, lnk_cc, app_cc;
  logic cfg_slow = 1'b0, app_ready, app_done, lnk_start, lnk_retry, lnk_idle_low;
  logic lnk_done, lnk_has_cc, lnk_all_zero, sem_err;
  logic [2:0] cfg_fault = 3'h0, app_result, retry_log;
  logic [1:0] cfg_fail_n = 2'h0, lnk_domain, lnk_fcs, frame_cnt;
  int fails = 0, total_checks = 0, idle_cnt = 0;

  always #20 core_clk = ~core_clk;
  // Count cycles the bus is forced low.
  always @(posedge core_clk) if (lnk_idle_low === 1'b1) idle_cnt <= idle_cnt + 1;

  scr_originator #(.IDLE_CYCLES(IDLE_N)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .app_req_valid(app_req_valid), .app_opcode(app_opcode), .app_wellformed(app_wellformed),
    .app_ready(app_ready), .app_done(app_done), .app_result(app_result), .app_cc(app_cc),
    .lnk_start(lnk_start), .lnk_opcode(lnk_opcode), .lnk_domain(lnk_domain),
    .lnk_retry(lnk_retry), .lnk_idle_low(lnk_idle_low), .lnk_done(lnk_done),
    .lnk_fcs(lnk_fcs), .lnk_has_cc(lnk_has_cc), .lnk_cc(lnk_cc), .lnk_all_zero(lnk_all_zero));
  scr_client_model #(.INFO_OPC(INFO_OPC), .PROTO_REV(PROTO_REV)) model_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .cfg_slow(cfg_slow),
    .cfg_fault(cfg_fault), .cfg_code(cfg_code), .cfg_fail_n(cfg_fail_n),
    .lnk_start(lnk_start), .lnk_opcode(lnk_opcode), .lnk_domain(lnk_domain),
    .lnk_retry(lnk_retry), .lnk_done(lnk_done), .lnk_fcs(lnk_fcs), .lnk_has_cc(lnk_has_cc),
    .lnk_cc(lnk_cc), .lnk_all_zero(lnk_all_zero), .frame_cnt(frame_cnt),
    .retry_log(retry_log), .sem_err(sem_err));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Runs one command to completion and judges result, code, frames and retry bits.
  task automatic cmd(input logic [7:0] op, input logic wf, input logic [2:0] fault,
      input logic [7:0] code, input logic [1:0] nfail, input logic [2:0] res,
      input logic [7:0] cc, input logic [1:0] n);
    int k;
    {cfg_fault, cfg_code, cfg_fail_n, app_opcode, app_wellformed} = {fault, code, nfail, op, wf};
    idle_cnt = 0;
    for (k = 0; k < 50 && app_ready !== 1'b1; k++) @(posedge core_clk) #1;
    chk("ready", 8'h1, {7'h0, app_ready});
    app_req_valid = 1'b1;
    @(posedge core_clk) #1;
    app_req_valid = 1'b0;
    for (k = 0; k < 2000 && app_done !== 1'b1; k++) @(posedge core_clk) #1;
    chk("done", 8'h1, {7'h0, app_done});
    chk("result", {5'h0, res}, {5'h0, app_result});
    chk("code", cc, app_cc);
    chk("frames", {6'h0, n}, {6'h0, frame_cnt});
    chk("retry_bits", {5'h0, 3'((1 << (n - 1)) - 1)}, {5'h0, retry_log});
  endtask

  // Every opcode passes at once, back to back, with its domain field.
  task automatic t_opcodes();
    logic [7:0] ops [14] = '{8'h01, 8'h02, 8'hA1, 8'hA2, 8'hA5, 8'hA6, 8'hB1, 8'hB2,
                             8'h61, 8'h62, 8'hE1, 8'hE2, 8'hE5, 8'hE6};
    for (int i = 0; i < 14; i++)
    begin
      cfg_slow = i[1];
      cmd(ops[i], 1'b1, 3'h0, 8'h0, 2'h0, RES_PASS, 8'h40, 2'h1);
      chk("domain", i[0] ? 8'h2 : 8'h1, {6'h0, lnk_domain});
      chk("opcode", ops[i], lnk_opcode);
    end
  endtask

  // Retry-class codes are retried up to three frames.
  task automatic t_retry_codes();
    logic [7:0] codes [4] = '{8'h80, 8'h81, 8'h82, 8'h8C};
    cmd(8'h01, 1'b1, 3'h4, 8'h80, 2'h1, RES_PASS, 8'h40, 2'h2);
    foreach (codes[i])
      cmd(8'hB1, 1'b1, 3'h4, codes[i], 2'h3, RES_NO_RESP, codes[i], 2'h3);
    chk("sem_retry", 8'h0, {7'h0, sem_err});
  endtask

  // Failing codes outside the retry class end the command after one frame.
  task automatic t_fatal_codes();
    logic [7:0] codes [3] = '{8'h91, 8'h9E, 8'hC5};
    cmd(8'hA1, 1'b1, 3'h4, 8'h90, 2'h3, RES_UNSUPP, 8'h90, 2'h1);
    foreach (codes[i])
      cmd(8'hA1, 1'b1, 3'h4, codes[i], 2'h3, RES_ABANDON, codes[i], 2'h1);
    cmd(8'hE1, 1'b1, 3'h4, 8'h7F, 2'h1, RES_PASS, 8'h7F, 2'h1);
    cmd(INFO_OPC, 1'b1, 3'h0, 8'h0, 2'h0, RES_PASS, PROTO_REV, 2'h1);
  endtask

  // Bad frame checks on well-formed commands, and aborted ones well formed or not.
  task automatic t_frame_checks();
    cmd(8'h61, 1'b1, 3'h1, 8'h0, 2'h1, RES_PASS, 8'h40, 2'h2);
    cmd(8'h61, 1'b1, 3'h1, 8'h0, 2'h3, RES_DEV_ERR, 8'h00, 2'h3);
    cmd(8'hA5, 1'b1, 3'h2, 8'h0, 2'h3, RES_DEV_ERR, 8'h00, 2'h3);
    cmd(8'hA5, 1'b0, 3'h2, 8'h0, 2'h3, RES_UNSUPP, 8'h00, 2'h3);
    cmd(8'h33, 1'b0, 3'h0, 8'h0, 2'h0, RES_UNSUPP, 8'h00, 2'h3);
    chk("domain", 8'h0, {6'h0, lnk_domain});
  endtask

  // All-zero answers force the bus idle before each retry.
  task automatic t_all_zero();
    cmd(8'h02, 1'b1, 3'h3, 8'h0, 2'h1, RES_PASS, 8'h40, 2'h2);
    chk("idle_cycles", 8'(IDLE_N), 8'(idle_cnt));
    cmd(8'h02, 1'b1, 3'h3, 8'h0, 2'h3, RES_UNRESP, 8'h00, 2'h3);
    chk("idle_cycles", 8'(2 * IDLE_N), 8'(idle_cnt));
  endtask

  // A reset in mid-command drops the request; the next command runs normally.
  task automatic t_mid_reset();
    cfg_slow = 1'b1;
    app_opcode = 8'hE5;
    app_req_valid = 1'b1;
    @(posedge core_clk) #1;
    app_req_valid = 1'b0;
    repeat (4) @(posedge core_clk) #1;
    sys_rst = 1'b1;
    @(posedge core_clk) #1;
    chk("ready_in_reset", 8'h0, {7'h0, app_ready});
    sys_rst = 1'b0;
    repeat (20) @(posedge core_clk) #1;
    cfg_slow = 1'b0;
    cmd(8'hE6, 1'b1, 3'h0, 8'h0, 2'h0, RES_PASS, 8'h40, 2'h1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: far beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    t_opcodes();
    t_retry_codes();
    t_fatal_codes();
    t_frame_checks();
    t_all_zero();
    t_mid_reset();
    close_out();
  end
endmodule
